// file: hdl/cci_core.sv
// Decode and execute of control, inherent and indirect-addressing instructions
`timescale 1ns/1ps

// Behaviour
// - Taken transfers cost two cycles, second idle
// - Upper-half pointer access adds one cycle
// - Accumulator branch adds W to counter
// - Accumulator call pushes return address
// - Literal return loads W and pops
// - Option load copies W, flags untouched
// - Port direction load copies W by index
// - Sleep enters standby, sets timeout flag, clears power-down flag
// - Pointer add uses sign-extended six-bit literal
// - Pointer arithmetic wraps modulo 65536
// - Indirect load with inc/dec, zero flag
// - Indexed load, pointer unchanged, zero flag
// - Indirect store with inc/dec, flags untouched
// - Indexed store, pointer and flags untouched
// - Immediate AND into W, zero only
// - Immediate add updates carry, digit, zero
// - Register AND to W or file
module cci_core (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  output logic instr_ready_o,
  input wire logic [6:0] pclath_i,
  input wire logic wake_i,
  output cci_pkg::cci_mem_req_s mem_req_o,
  input wire logic [7:0] mem_rdata_i,
  output logic [cci_pkg::PC_W-1:0] pc_o,
  output logic [7:0] w_o,
  output cci_pkg::cci_status_s status_o,
  output logic [7:0] option_o,
  output logic [cci_pkg::PORT_DIR_N*8-1:0] port_dir_o,
  output logic [cci_pkg::PTR_W-1:0] fsr0_o,
  output logic [cci_pkg::PTR_W-1:0] fsr1_o,
  output logic sleeping_o,
  output logic soft_reset_o,
  output logic wdt_clear_o,
  output logic int_return_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  cci_pkg::cci_op_e op;
  cci_pkg::cci_state_e state_q;
  logic fire;

  function automatic logic hit(input logic [13:0] ins, input logic [13:0] msk, input logic [13:0] val);
    hit = (ins & msk) == val;
  endfunction

  // Exact codes first: the port-direction pattern overlaps them
  always_comb begin
    op = cci_pkg::OP_OTHER;
    if (hit(instr_i, cci_pkg::MSK_EXACT, cci_pkg::OPC_NOP)) op = cci_pkg::OP_NOP;
    else if (hit(instr_i, cci_pkg::MSK_EXACT, cci_pkg::OPC_SOFT_RESET)) op = cci_pkg::OP_SOFT_RESET;
    else if (hit(instr_i, cci_pkg::MSK_EXACT, cci_pkg::OPC_RETURN)) op = cci_pkg::OP_RETURN;
    else if (hit(instr_i, cci_pkg::MSK_EXACT, cci_pkg::OPC_RET_INT)) op = cci_pkg::OP_RET_INT;
    else if (hit(instr_i, cci_pkg::MSK_EXACT, cci_pkg::OPC_CALL_W)) op = cci_pkg::OP_CALL_W;
    else if (hit(instr_i, cci_pkg::MSK_EXACT, cci_pkg::OPC_BRANCH_W)) op = cci_pkg::OP_BRANCH_W;
    else if (hit(instr_i, cci_pkg::MSK_EXACT, cci_pkg::OPC_OPTION)) op = cci_pkg::OP_OPTION;
    else if (hit(instr_i, cci_pkg::MSK_EXACT, cci_pkg::OPC_SLEEP)) op = cci_pkg::OP_SLEEP;
    else if (hit(instr_i, cci_pkg::MSK_EXACT, cci_pkg::OPC_WDT_KICK)) op = cci_pkg::OP_WDT_KICK;
    else if (hit(instr_i, cci_pkg::MSK_LOW3, cci_pkg::OPC_PORT_DIR)) op = cci_pkg::OP_PORT_DIR;
    else if (hit(instr_i, cci_pkg::MSK_LOW3, cci_pkg::OPC_LOAD_MM)) op = cci_pkg::OP_LOAD_MM;
    else if (hit(instr_i, cci_pkg::MSK_LOW3, cci_pkg::OPC_STORE_MM)) op = cci_pkg::OP_STORE_MM;
    else if (hit(instr_i, cci_pkg::MSK_K6, cci_pkg::OPC_ADD_PTR)) op = cci_pkg::OP_ADD_PTR;
    else if (hit(instr_i, cci_pkg::MSK_K6, cci_pkg::OPC_LOAD_IDX)) op = cci_pkg::OP_LOAD_IDX;
    else if (hit(instr_i, cci_pkg::MSK_K6, cci_pkg::OPC_STORE_IDX)) op = cci_pkg::OP_STORE_IDX;
    else if (hit(instr_i, cci_pkg::MSK_K9, cci_pkg::OPC_BRANCH)) op = cci_pkg::OP_BRANCH;
    else if (hit(instr_i, cci_pkg::MSK_K11, cci_pkg::OPC_CALL)) op = cci_pkg::OP_CALL;
    else if (hit(instr_i, cci_pkg::MSK_K11, cci_pkg::OPC_GOTO)) op = cci_pkg::OP_GOTO;
    else if (hit(instr_i, cci_pkg::MSK_K8, cci_pkg::OPC_RET_LIT)) op = cci_pkg::OP_RET_LIT;
    else if (hit(instr_i, cci_pkg::MSK_K8, cci_pkg::OPC_AND_IMM)) op = cci_pkg::OP_AND_IMM;
    else if (hit(instr_i, cci_pkg::MSK_K8, cci_pkg::OPC_ADD_IMM)) op = cci_pkg::OP_ADD_IMM;
    else if (hit(instr_i, cci_pkg::MSK_K8, cci_pkg::OPC_AND_REG)) op = cci_pkg::OP_AND_REG;
  end

  assign instr_ready_o = (state_q == cci_pkg::ST_EXEC);
  assign fire = instr_valid_i && instr_ready_o;

  logic is_mm, is_idx, is_ind, is_load, two_cycle;
  assign is_mm = (op == cci_pkg::OP_LOAD_MM) || (op == cci_pkg::OP_STORE_MM);
  assign is_idx = (op == cci_pkg::OP_LOAD_IDX) || (op == cci_pkg::OP_STORE_IDX);
  assign is_ind = is_mm || is_idx;
  assign is_load = (op == cci_pkg::OP_LOAD_MM) || (op == cci_pkg::OP_LOAD_IDX);
  assign two_cycle = op inside {cci_pkg::OP_BRANCH, cci_pkg::OP_BRANCH_W, cci_pkg::OP_CALL, cci_pkg::OP_CALL_W,
                                cci_pkg::OP_GOTO, cci_pkg::OP_RET_INT, cci_pkg::OP_RET_LIT, cci_pkg::OP_RETURN};

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  logic [cci_pkg::PTR_W-1:0] fsr_q [cci_pkg::FSR_N];
  logic sel_n, slow;
  logic [cci_pkg::PTR_W-1:0] ptr, k6_ext, ptr_step, eff_addr, ptr_next;

  assign sel_n = is_mm ? instr_i[cci_pkg::MM_PTR_BIT] : instr_i[cci_pkg::K6_PTR_BIT];
  assign ptr = fsr_q[sel_n];
  assign k6_ext = {{(cci_pkg::PTR_W-6){instr_i[cci_pkg::K6_SIGN]}}, instr_i[5:0]};
  // mm: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; 16-bit sums wrap by width
  assign ptr_step = instr_i[0] ? ptr - cci_pkg::PTR_STEP : ptr + cci_pkg::PTR_STEP;
  assign eff_addr = is_idx ? ptr + k6_ext : (instr_i[1] ? ptr : ptr_step);
  assign ptr_next = (op == cci_pkg::OP_ADD_PTR) ? ptr + k6_ext : ptr_step;
  assign slow = is_ind && eff_addr[cci_pkg::PTR_W-1];

  // ----------------------------------------------------------------
  // State sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= cci_pkg::ST_EXEC;
    end else begin
      unique case (state_q)
        cci_pkg::ST_EXEC: begin
          if (fire && two_cycle) state_q <= cci_pkg::ST_NOP2;
          else if (fire && slow) state_q <= cci_pkg::ST_XTRA;
          else if (fire && op == cci_pkg::OP_SLEEP) state_q <= cci_pkg::ST_SLEEP;
        end
        cci_pkg::ST_NOP2: state_q <= cci_pkg::ST_EXEC;
        cci_pkg::ST_XTRA: state_q <= cci_pkg::ST_EXEC;
        cci_pkg::ST_SLEEP: if (wake_i) state_q <= cci_pkg::ST_EXEC;
      endcase
    end
  end

  // Slow accesses are issued only from these, in the added cycle
  logic [cci_pkg::PTR_W-1:0] xtra_addr_q;
  logic xtra_load_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xtra_addr_q <= cci_pkg::PTR_RST;
      xtra_load_q <= 1'b0;
    end else if (fire && slow) begin
      xtra_addr_q <= eff_addr;
      xtra_load_q <= is_load;
    end
  end

  // ----------------------------------------------------------------
  // Memory access
  // ----------------------------------------------------------------
  logic [7:0] w_q;
  logic [7:0] and_res;
  assign and_res = w_q & mem_rdata_i;

  always_comb begin
    mem_req_o = '0;
    if (state_q == cci_pkg::ST_XTRA) begin
      mem_req_o.re = xtra_load_q;
      mem_req_o.we = !xtra_load_q;
      mem_req_o.addr = xtra_addr_q;
      mem_req_o.wdata = w_q;
    end else if (fire && is_ind && !slow) begin
      mem_req_o.re = is_load;
      mem_req_o.we = !is_load;
      mem_req_o.addr = eff_addr;
      mem_req_o.wdata = w_q;
    end else if (fire && op == cci_pkg::OP_AND_REG) begin
      mem_req_o.re = 1'b1;
      mem_req_o.we = instr_i[cci_pkg::DEST_BIT];
      mem_req_o.addr = {cci_pkg::FILE_BANK0, instr_i[6:0]};
      mem_req_o.wdata = and_res;
    end
  end

  // ----------------------------------------------------------------
  // Program counter and stack
  // ----------------------------------------------------------------
  logic [cci_pkg::PC_W-1:0] pc_q, pc_inc, stack_top;
  logic push, pop;
  assign pc_inc = pc_q + cci_pkg::PC_STEP;
  assign push = fire && (op == cci_pkg::OP_CALL || op == cci_pkg::OP_CALL_W);
  assign pop = fire && (op inside {cci_pkg::OP_RETURN, cci_pkg::OP_RET_INT, cci_pkg::OP_RET_LIT});

  cci_hw_stack u_stack (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .push_i(push),
    .pop_i(pop),
    .push_data_i(pc_inc),
    .top_o(stack_top)
  );

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_q <= cci_pkg::PC_RST;
    end else if (fire) begin
      unique case (op)
        cci_pkg::OP_BRANCH: pc_q <= pc_inc + {{(cci_pkg::PC_W-9){instr_i[cci_pkg::K9_SIGN]}}, instr_i[8:0]};
        cci_pkg::OP_BRANCH_W: pc_q <= pc_inc + {{(cci_pkg::PC_W-8){1'b0}}, w_q};
        cci_pkg::OP_CALL, cci_pkg::OP_GOTO: pc_q <= {pclath_i[6:3], instr_i[10:0]};
        cci_pkg::OP_CALL_W: pc_q <= {pclath_i, w_q};
        cci_pkg::OP_RETURN, cci_pkg::OP_RET_INT, cci_pkg::OP_RET_LIT: pc_q <= stack_top;
        default: pc_q <= pc_inc;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------
  logic [8:0] add_sum;
  logic [4:0] add_low;
  cci_pkg::cci_status_s status_q;
  assign add_sum = {1'b0, w_q} + {1'b0, instr_i[7:0]};
  assign add_low = {1'b0, w_q[3:0]} + {1'b0, instr_i[3:0]};

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_q <= cci_pkg::BYTE_ZERO;
    end else if (state_q == cci_pkg::ST_XTRA && xtra_load_q) begin
      w_q <= mem_rdata_i;
    end else if (fire) begin
      unique case (op)
        cci_pkg::OP_RET_LIT: w_q <= instr_i[7:0];
        cci_pkg::OP_AND_IMM: w_q <= w_q & instr_i[7:0];
        cci_pkg::OP_ADD_IMM: w_q <= add_sum[7:0];
        cci_pkg::OP_AND_REG: if (!instr_i[cci_pkg::DEST_BIT]) w_q <= and_res;
        cci_pkg::OP_LOAD_MM, cci_pkg::OP_LOAD_IDX: if (!slow) w_q <= mem_rdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= cci_pkg::STATUS_RST;
    end else if (state_q == cci_pkg::ST_XTRA && xtra_load_q) begin
      status_q.z <= (mem_rdata_i == cci_pkg::BYTE_ZERO);
    end else if (fire) begin
      unique case (op)
        cci_pkg::OP_AND_IMM: status_q.z <= ((w_q & instr_i[7:0]) == cci_pkg::BYTE_ZERO);
        cci_pkg::OP_ADD_IMM: begin
          status_q.c <= add_sum[8];
          status_q.digit_carry_flag <= add_low[4];
          status_q.z <= (add_sum[7:0] == cci_pkg::BYTE_ZERO);
        end
        cci_pkg::OP_AND_REG: status_q.z <= (and_res == cci_pkg::BYTE_ZERO);
        cci_pkg::OP_LOAD_MM, cci_pkg::OP_LOAD_IDX: if (!slow) status_q.z <= (mem_rdata_i == cci_pkg::BYTE_ZERO);
        cci_pkg::OP_SLEEP: begin
          status_q.timeout_flag <= 1'b1;
          status_q.power_down_flag <= 1'b0;
        end
        cci_pkg::OP_WDT_KICK: begin
          status_q.timeout_flag <= 1'b1;
          status_q.power_down_flag <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < cci_pkg::FSR_N; i++) begin : g_fsr
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        fsr_q[i] <= cci_pkg::PTR_RST;
      end else if (fire && sel_n == 1'(i) && (is_mm || op == cci_pkg::OP_ADD_PTR)) begin
        fsr_q[i] <= ptr_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers and pulses
  // ----------------------------------------------------------------
  logic [7:0] option_q;
  logic [7:0] port_dir_q [cci_pkg::PORT_DIR_N];
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      option_q <= cci_pkg::OPTION_RST;
    end else if (fire && op == cci_pkg::OP_OPTION) begin
      option_q <= w_q;
    end
  end

  for (genvar i = 0; i < cci_pkg::PORT_DIR_N; i++) begin : g_dir
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        port_dir_q[i] <= cci_pkg::PORT_DIR_RST;
      end else if (fire && op == cci_pkg::OP_PORT_DIR && instr_i[2:0] == 3'(i)) begin
        port_dir_q[i] <= w_q;
      end
    end
    assign port_dir_o[i*8 +: 8] = port_dir_q[i];
  end

  // One-cycle requests to the reset, watchdog and interrupt logic
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_reset_o <= 1'b0;
      wdt_clear_o <= 1'b0;
      int_return_o <= 1'b0;
    end else begin
      soft_reset_o <= fire && op == cci_pkg::OP_SOFT_RESET;
      wdt_clear_o <= fire && op == cci_pkg::OP_WDT_KICK;
      int_return_o <= fire && op == cci_pkg::OP_RET_INT;
    end
  end

  assign pc_o = pc_q;
  assign w_o = w_q;
  assign status_o = status_q;
  assign option_o = option_q;
  assign fsr0_o = fsr_q[0];
  assign fsr1_o = fsr_q[1];
  assign sleeping_o = (state_q == cci_pkg::ST_SLEEP);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  two_cycle_a: assert property (fire && two_cycle |=> !instr_ready_o ##1 instr_ready_o)
    else $error("transfer not two cycles");
  extra_cycle_a: assert property (fire && slow |=> state_q == cci_pkg::ST_XTRA
                                  && mem_req_o.addr == $past(eff_addr))
    else $error("slow indirect missing extra cycle");
  branch_w_a: assert property (fire && op == cci_pkg::OP_BRANCH_W |=> pc_q == $past(pc_inc) + 15'($past(w_q)))
    else $error("accumulator branch target wrong");
  call_w_a: assert property (fire && op == cci_pkg::OP_CALL_W |=>
                             stack_top == $past(pc_inc) ##1 instr_ready_o)
    else $error("accumulator call return address wrong");
  ret_lit_a: assert property (fire && op == cci_pkg::OP_RET_LIT |=> w_q == $past(instr_i[7:0])
                              && pc_q == $past(stack_top))
    else $error("literal return wrong");
  option_a: assert property (fire && op == cci_pkg::OP_OPTION |=> option_q == $past(w_q) && $stable(status_q))
    else $error("option load wrong");
  sleep_a: assert property (fire && op == cci_pkg::OP_SLEEP |=> sleeping_o && status_q.timeout_flag
                            && !status_q.power_down_flag)
    else $error("sleep entry wrong");
  add_ptr_a: assert property (fire && op == cci_pkg::OP_ADD_PTR && !sel_n |=>
                              fsr_q[0] == $past(ptr) + $past(k6_ext))
    else $error("pointer add wrong");
  and_imm_a: assert property (fire && op == cci_pkg::OP_AND_IMM |=> w_q == ($past(w_q) & $past(instr_i[7:0]))
                              && status_q.c == $past(status_q.c))
    else $error("immediate and wrong");

  cover property (fire && slow ##1 state_q == cci_pkg::ST_XTRA);
  cover property (fire && op == cci_pkg::OP_CALL ##[2:3] fire
                  && (op == cci_pkg::OP_RETURN || op == cci_pkg::OP_RET_INT));
  cover property (sleeping_o && wake_i ##1 instr_ready_o);

endmodule // cci_core

// file: hdl/cci_pkg.sv
// Shared constants, opcodes and carrier types for the CPU control and indirect-ops core
package cci_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int unsigned PC_W = 15;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned STACK_DEPTH = 16;
  localparam int unsigned STACK_PTR_W = 4;
  localparam int unsigned PORT_DIR_N = 8;
  localparam int unsigned FSR_N = 2;

  // ----------------------------------------------------------------
  // Opcode masks and match values
  // ----------------------------------------------------------------
  localparam logic [13:0] MSK_EXACT = 14'h3fff;
  localparam logic [13:0] MSK_LOW3 = 14'h3ff8;
  localparam logic [13:0] MSK_K6 = 14'h3f80;
  localparam logic [13:0] MSK_K8 = 14'h3f00;
  localparam logic [13:0] MSK_K9 = 14'h3e00;
  localparam logic [13:0] MSK_K11 = 14'h3800;

  localparam logic [13:0] OPC_NOP = 14'h0000;
  localparam logic [13:0] OPC_SOFT_RESET = 14'h0001;
  localparam logic [13:0] OPC_RETURN = 14'h0008;
  localparam logic [13:0] OPC_RET_INT = 14'h0009;
  localparam logic [13:0] OPC_CALL_W = 14'h000a;
  localparam logic [13:0] OPC_BRANCH_W = 14'h000b;
  localparam logic [13:0] OPC_OPTION = 14'h0062;
  localparam logic [13:0] OPC_SLEEP = 14'h0063;
  localparam logic [13:0] OPC_WDT_KICK = 14'h0064;
  localparam logic [13:0] OPC_PORT_DIR = 14'h0060;
  localparam logic [13:0] OPC_LOAD_MM = 14'h0010;
  localparam logic [13:0] OPC_STORE_MM = 14'h0018;
  localparam logic [13:0] OPC_ADD_PTR = 14'h3100;
  localparam logic [13:0] OPC_LOAD_IDX = 14'h3f00;
  localparam logic [13:0] OPC_STORE_IDX = 14'h3f80;
  localparam logic [13:0] OPC_BRANCH = 14'h3200;
  localparam logic [13:0] OPC_CALL = 14'h2000;
  localparam logic [13:0] OPC_GOTO = 14'h2800;
  localparam logic [13:0] OPC_RET_LIT = 14'h3400;
  localparam logic [13:0] OPC_AND_IMM = 14'h3900;
  localparam logic [13:0] OPC_ADD_IMM = 14'h3e00;
  localparam logic [13:0] OPC_AND_REG = 14'h0500;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned MM_PTR_BIT = 2;
  localparam int unsigned K6_PTR_BIT = 6;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned K6_SIGN = 5;
  localparam int unsigned K9_SIGN = 8;

  // ----------------------------------------------------------------
  // Reset values and steps
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;
  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] PORT_DIR_RST = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [8:0] FILE_BANK0 = 9'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic timeout_flag;
    logic power_down_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } cci_status_s;

  localparam cci_status_s STATUS_RST = '{timeout_flag: 1'b1, power_down_flag: 1'b1, z: 1'b0,
                                         digit_carry_flag: 1'b0, c: 1'b0};

  typedef struct packed {
    logic re;
    logic we;
    logic [PTR_W-1:0] addr;
    logic [7:0] wdata;
  } cci_mem_req_s;

  typedef enum logic [1:0] {
    ST_EXEC = 2'h0,
    ST_NOP2 = 2'h1,
    ST_XTRA = 2'h3,
    ST_SLEEP = 2'h2
  } cci_state_e;

  typedef enum logic [4:0] {
    OP_NOP, OP_SOFT_RESET, OP_RETURN, OP_RET_INT, OP_CALL_W, OP_BRANCH_W, OP_OPTION,
    OP_SLEEP, OP_WDT_KICK, OP_PORT_DIR, OP_LOAD_MM, OP_STORE_MM, OP_ADD_PTR, OP_LOAD_IDX,
    OP_STORE_IDX, OP_BRANCH, OP_CALL, OP_GOTO, OP_RET_LIT, OP_AND_IMM, OP_ADD_IMM, OP_AND_REG,
    OP_OTHER
  } cci_op_e;

endpackage

// file: hdl/cci_hw_stack.sv
// Return-address stack held in flip-flops
`timescale 1ns/1ps

module cci_hw_stack (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [cci_pkg::PC_W-1:0] push_data_i,
  output logic [cci_pkg::PC_W-1:0] top_o
);

  logic [cci_pkg::STACK_PTR_W-1:0] ptr_q;
  logic [cci_pkg::PC_W-1:0] ent_q [cci_pkg::STACK_DEPTH];

  // Pointer wraps silently; overflow reset is outside this core
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_q <= '0;
    end else if (push_i) begin
      ptr_q <= ptr_q + 1'b1;
    end else if (pop_i) begin
      ptr_q <= ptr_q - 1'b1;
    end
  end

  for (genvar i = 0; i < cci_pkg::STACK_DEPTH; i++) begin : g_ent
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ent_q[i] <= cci_pkg::PC_RST;
      end else if (push_i && ptr_q == cci_pkg::STACK_PTR_W'(i)) begin
        ent_q[i] <= push_data_i;
      end
    end
  end

  assign top_o = ent_q[ptr_q - 1'b1];

endmodule // cci_hw_stack

// file: test/test_cci_core.sv
// Self-checking bench for the control and indirect-ops core
`timescale 1ns/1ps

module test_cci_core;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [6:0] pclath_i = 7'h00;
  logic wake_i = 1'b0;
  logic [7:0] rd_val = 8'h00;
  logic [7:0] mem_rdata;
  logic instr_ready_o, sleeping_o, soft_reset_o, wdt_clear_o, int_return_o;
  logic [7:0] w_o, option_o;
  logic [14:0] pc_o;
  logic [63:0] port_dir_o;
  logic [15:0] fsr0_o, fsr1_o;
  cci_pkg::cci_mem_req_s mem_req_o, req;
  cci_pkg::cci_status_s status_o;
  int err_count = 0;
  int comparisons = 0;

  // Unrequested read data is inverted so a stale byte cannot pass
  assign mem_rdata = mem_req_o.re ? rd_val : ~rd_val;

  cci_core cci_core_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o), .pclath_i(pclath_i), .wake_i(wake_i),
    .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata), .pc_o(pc_o), .w_o(w_o), .status_o(status_o),
    .option_o(option_o), .port_dir_o(port_dir_o), .fsr0_o(fsr0_o), .fsr1_o(fsr1_o),
    .sleeping_o(sleeping_o), .soft_reset_o(soft_reset_o), .wdt_clear_o(wdt_clear_o),
    .int_return_o(int_return_o));

  always #2 clock_i = ~clock_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Holds the word until taken; returns in the cycle after the fire edge
  task automatic issue(input logic [13:0] op);
    int n;
    n = 0;
    @(negedge clock_i);
    instr_valid_i = 1'b1;
    instr_i = op;
    #1;
    while (instr_ready_o !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      #1;
      n++;
    end
    if (n >= 20) err_count++;
    req = mem_req_o;
    @(negedge clock_i);
    instr_valid_i = 1'b0;
  endtask

  task automatic t_arith();
    issue(14'h3e8f);
    chk(status_o, 16'h0018);
    issue(14'h3e71);
    chk({w_o, 3'h0, status_o}, 16'h001f);
    issue(14'h3e3c);
    issue(14'h39c3);
    chk({w_o, 3'h0, status_o}, 16'h001c);
    issue(14'h3e10);
  endtask

  task automatic t_flow();
    issue(14'h2923);
    chk(pc_o, 16'h0123);
    issue(14'h33fe);
    chk({instr_ready_o, pc_o}, 16'h0122);
    pclath_i = 7'h01;
    issue(14'h000a);
    chk(pc_o, 16'h0110);
    issue(14'h0008);
    chk(pc_o, 16'h0123);
    issue(14'h2050);
    chk(pc_o, 16'h0050);
    issue(14'h3477);
    chk({w_o, 1'b0, pc_o[6:0]}, 16'h7724);
    issue(14'h000b);
    chk(pc_o, 16'h019c);
    issue(14'h2050);
    issue(14'h0009);
    chk({int_return_o, pc_o}, 16'h819d);
  endtask

  task automatic t_regs();
    issue(14'h0062);
    chk({option_o, 3'h0, status_o}, 16'h7718);
    issue(14'h0065);
    chk(port_dir_o[47:40], 16'h0077);
  endtask

  task automatic t_ptr();
    issue(14'h313f);
    chk(fsr0_o, 16'hffff);
    issue(14'h3101);
    chk(fsr0_o, 16'h0000);
    issue(14'h315f);
    chk(fsr1_o, 16'h001f);
  endtask

  task automatic t_mem();
    issue(14'h0016);
    chk(req.addr, 16'h001f);
    chk({w_o, 3'h0, status_o}, 16'h001c);
    chk(fsr1_o, 16'h0020);
    rd_val = 8'h81;
    issue(14'h3f42);
    chk({req.re, req.addr[14:0]}, 16'h8022);
    chk({w_o, fsr1_o[7:0]}, 16'h8120);
    issue(14'h3ffe);
    chk({req.we, req.addr[14:0]}, 16'h801e);
    chk({req.wdata, fsr1_o[7:0]}, 16'h8120);
    rd_val = 8'h0f;
    issue(14'h0595);
    chk({req.we, req.addr[14:0]}, 16'h8015);
    chk({req.wdata, w_o}, 16'h0181);
    issue(14'h0515);
    chk({req.re, req.we, 6'h00, w_o}, 16'h8001);
    issue(14'h001c);
    chk({req.we, req.addr[14:0]}, 16'h8021);
    chk({req.wdata, fsr1_o[7:0]}, 16'h0121);
    issue(14'h0017);
    chk({req.re, req.addr[14:0]}, 16'h8021);
    chk({w_o, fsr1_o[7:0]}, 16'h0f20);
  endtask

  task automatic t_slow();
    issue(14'h313f);
    issue(14'h0019);
    chk({req.we, instr_ready_o, mem_req_o.we}, 16'h0001);
    chk(mem_req_o.addr, 16'hfffe);
    chk({mem_req_o.wdata, 3'h0, status_o}, 16'h0f18);
    chk(fsr0_o, 16'hfffe);
  endtask

  task automatic t_power();
    issue(14'h0063);
    chk(16'({sleeping_o, instr_ready_o, status_o}), 16'h0050);
    wake_i = 1'b1;
    @(negedge clock_i);
    wake_i = 1'b0;
    issue(14'h0064);
    chk({wdt_clear_o, status_o}, 16'h0038);
    issue(14'h0001);
    chk(soft_reset_o, 16'h0001);
  endtask

  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // About 31 instructions (some 80 clock cycles) are needed; the margin is generous
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (16) @(negedge clock_i);
    arst_n_i = 1'b1;
    t_arith();
    t_flow();
    t_regs();
    t_ptr();
    t_mem();
    t_slow();
    t_power();
    wrap_up();
  end
endmodule // test_cci_core
